// >>> pcc_checker.sv
// Purpose: Port-level assertions for the PLL configuration block.
// Assumes: Zero-wait APB writes land at the access edge, clk_en high.
// Notes:   Shadows of the misc and gain fields are kept from bus writes.
`timescale 1ns/10ps
module pcc_checker (
    // Clock, reset and bus
    input wire        pclk,
    input wire        presetn,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Watched pins
    input wire        digital_lock,
    input wire        output_gate_pin,
    input wire [7:0]  per_output_gate,
    input wire        lock_status_pin_o,
    input wire        lock_status_pin_oe,
    input wire [7:0]  clock_out_enable,
    input wire        vco_tap_enable,
    input wire        device_sleep,
    input wire [5:0]  pump_gain,
    input wire        cal_busy
);
    reg  [7:0] misc_ff;
    reg  [1:0] gain_ff;
    wire       wr_ok = psel & penable & pwrite & clk_en;
    wire [3:0] sel   = misc_ff[3:0];
    wire       awake = !misc_ff[4];

    // Shadow copies, so every pin can be tied to the value that set it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc_ff <= 8'h20;
            gain_ff <= 2'h0;
        end else if (wr_ok && paddr == 12'h000) begin
            misc_ff <= pwdata[7:0];
        end else if (wr_ok && paddr == 12'h004) begin
            gain_ff <= pwdata[23:22];
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pin_float:
        assert property ((!awake || sel == 4'h0 || sel == 4'h8 || sel == 4'ha || sel > 4'hb) |-> !lock_status_pin_oe)
        else $error("lock pin driven while disabled");
    a_pin_level:
        assert property (awake && (sel == 4'h1 || sel == 4'h2) |-> lock_status_pin_oe && lock_status_pin_o == (sel == 4'h1))
        else $error("lock pin fixed level wrong");
    a_dlock_pin:
        assert property (awake && (sel == 4'h3 || sel == 4'h4) |-> lock_status_pin_oe
                         && lock_status_pin_o == (digital_lock ^ (sel == 4'h4)))
        else $error("digital lock on pin wrong");
    a_sleep_off:
        assert property (device_sleep |-> clock_out_enable == 8'h00 && !cal_busy && device_sleep == !awake)
        else $error("sleep left a block running");
    a_gate_off:
        assert property (!misc_ff[5] || !output_gate_pin |-> clock_out_enable == 8'h00)
        else $error("outputs on with gate closed");
    a_gate_pass:
        assert property (misc_ff[5] && output_gate_pin && awake |-> clock_out_enable == per_output_gate)
        else $error("outputs not following enables");
    a_tap_follow:
        assert property (awake |-> vco_tap_enable == misc_ff[6])
        else $error("tap enable wrong");
    a_cal_start:
        assert property (wr_ok && paddr == 12'h004 && awake |=> cal_busy ##1 (cal_busy || !awake)[*7])
        else $error("calibration did not start");
    a_gain_map:
        assert property (pump_gain == (gain_ff == 2'h3 ? 6'h20 : 6'h01 << (2 * gain_ff)))
        else $error("pump gain wrong");
endmodule

bind pcc_top pcc_checker i_pcc_checker (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .digital_lock, .output_gate_pin, .per_output_gate, .lock_status_pin_o, .lock_status_pin_oe,
    .clock_out_enable, .vco_tap_enable, .device_sleep, .pump_gain, .cal_busy);

// >>> pcc_consts.vh
// Purpose: Constants for the PLL configuration and control block.
// Assumes: 32-bit APB register words, byte addresses.
// Notes:   Offsets are byte addresses of aligned words.
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PCC_OFF_MISC      12'h000
`define PCC_OFF_FEEDBACK  12'h004
`define PCC_OFF_STATUS    12'h008
`define PCC_OFF_IRQ_STAT  12'h00c
`define PCC_OFF_IRQ_MASK  12'h010

// ----------------------------------------------------------------------
// Miscellaneous control fields
// ----------------------------------------------------------------------
`define PCC_MISC_LSEL_LO     0
`define PCC_MISC_LSEL_HI     3
`define PCC_MISC_SLEEP_BIT   4
`define PCC_MISC_GATE_BIT    5
`define PCC_MISC_TAP_BIT     6
`define PCC_MISC_QUARTER_BIT 7
`define PCC_MISC_RESET       8'h20

// ----------------------------------------------------------------------
// Feedback control fields
// ----------------------------------------------------------------------
`define PCC_FB_N_LO       0
`define PCC_FB_N_HI       17
`define PCC_FB_PDIV_LO    18
`define PCC_FB_PDIV_HI    21
`define PCC_FB_GAIN_LO    22
`define PCC_FB_GAIN_HI    23
`define PCC_FB_N_RESET    18'h002f8
`define PCC_FB_PDIV_RESET 4'h2
`define PCC_FB_GAIN_RESET 2'h0

// ----------------------------------------------------------------------
// Lock pin select codes
// ----------------------------------------------------------------------
`define PCC_LSEL_HIZ      4'h0
`define PCC_LSEL_HIGH     4'h1
`define PCC_LSEL_LOW      4'h2
`define PCC_LSEL_DLD_H    4'h3
`define PCC_LSEL_DLD_L    4'h4
`define PCC_LSEL_ALD_PP   4'h5
`define PCC_LSEL_ALD_NMOS 4'h6
`define PCC_LSEL_ALD_PMOS 4'h7
`define PCC_LSEL_NDIV2    4'h9
`define PCC_LSEL_RDIV2    4'hb

// ----------------------------------------------------------------------
// Calibration timing
// ----------------------------------------------------------------------
`define PCC_CAL_TIME_US   10
`define PCC_CLK_MHZ       20
// Ten microseconds at 20 MHz, sized to the sixteen-bit calibration counter.
`define PCC_CAL_CYCLES    16'h00c8

`endif

// >>> pcc_divider.v
// Purpose: Programmable integer divider with a one-cycle output pulse.
// Assumes: Divide value is at least one; zero is treated as one.
// Notes:   Counts enabled input ticks; width fixed at eighteen bits.
`timescale 1ns/10ps
module pcc_divider (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // Control
    input  wire        run,
    input  wire [17:0] divide,
    input  wire        tick_in,
    // Output
    output reg         tick_out_ff
);

    reg  [17:0] count_ff;
    wire [17:0] last = (divide == 18'h00000) ? 18'h00000 : divide - 18'h00001;
    wire        wrap = (count_ff >= last);

    // Count input ticks and pulse on each wrap; stopping clears the count.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff    <= 18'h00000;
            tick_out_ff <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                count_ff    <= 18'h00000;
                tick_out_ff <= 1'b0;
            end else begin
                tick_out_ff <= tick_in & wrap;
                if (tick_in) begin
                    count_ff <= wrap ? 18'h00000 : count_ff + 18'h00001;
                end
            end
        end
    end

endmodule

// >>> pcc_halver.v
// Purpose: Turns a tick stream into a fifty percent duty square wave.
// Assumes: Ticks are single-cycle pulses.
// Notes:   Each tick flips the output, so the rate is halved.
`timescale 1ns/10ps
module pcc_halver (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    input  wire clk_en,
    // Data
    input  wire run,
    input  wire tick_in,
    output reg  wave_ff
);

    // Toggle on each tick; held low while stopped.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_ff <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                wave_ff <= 1'b0;
            end else if (tick_in) begin
                wave_ff <= ~wave_ff;
            end
        end
    end

endmodule

// >>> pcc_host.sv
// Purpose: APB host model that programs the PLL control registers.
// Assumes: Caller resumes only after a rising edge.
// Notes:   One idle cycle between transfers keeps every drive apart.
`timescale 1ns/10ps
module pcc_host (
    // Clock
    input  wire        pclk,
    // APB master side
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [11:0] paddr,
    output reg  [31:0] pwdata,
    input  wire        pready
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // One transfer; the request is held until pready is seen high.
    task xfer(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (!pready) @(posedge pclk);
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule

// >>> pcc_top.v
// Purpose: APB-programmed configuration and control for an integer-N PLL.
// Assumes: pclk 20 MHz; reference and VCO ticks are synchronous pulses.
// Notes:   Analog lock indications arrive as synchronous levels.
//
// Operation
// - Lock select 0 floats pin, 1 drives high, 2 drives low.
// - Codes 3/4 digital lock high/low; 5,6,7 analog push-pull, NMOS, PMOS.
// - Code 9 drives feedback divider output halved, square wave.
// - Code 11 drives reference divider output halved, square wave.
// - Sleep bit one shuts every block except pump gain and interrupts, regardless of other settings.
// - Gate bit zero disables all outputs over per-output enables.
// - VCO tap pin driven only when its enable bit is one.
// - Every write to the feedback register starts calibration.
// - Feedback divider is eighteen-bit binary, 1..262143, reset 760.
// - Post-divider precedes feedback divider; total is their product.
// - Post-divide codes 2..8 divide directly, reset 2, never bypassed.
// - Post-divider output feeds all distributed clock outputs.
// - Pump gain codes 0..3 select 1x, 4x, 16x, 32x.
`timescale 1ns/10ps
`include "pcc_consts.vh"
module pcc_top (
    // Clock, reset, enable
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Clock sources and lock indications
    input  wire        vco_tick,
    input  wire        ref_div_tick,
    input  wire        digital_lock,
    input  wire        analog_lock,
    input  wire        output_gate_pin,
    input  wire [7:0]  per_output_gate,
    // Lock status pin, three-signal form
    input  wire        lock_status_pin_i,
    output reg         lock_status_pin_o,
    output reg         lock_status_pin_oe,
    // Clock outputs and tap
    output wire [7:0]  clock_out_enable,
    output wire        dist_tick,
    output wire        vco_tap_enable,
    output wire        feedback_tick,
    // Analog controls
    output wire        device_sleep,
    output reg  [5:0]  pump_gain,
    output wire        lock_compare_quarter,
    output wire        cal_busy,
    output wire        irq
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [7:0]  misc_ff;
    reg  [17:0] fb_n_ff;
    reg  [3:0]  pdiv_ff;
    reg  [1:0]  gain_ff;
    reg  [15:0] cal_cnt_ff;
    reg  [2:0]  irq_stat_ff;
    reg  [2:0]  irq_mask_ff;
    reg         lock_prev_ff;
    reg  [2:0]  nxt_irq_stat;

    wire        wr_en  = psel & penable & pwrite & clk_en;
    wire        wr_fb  = wr_en & (paddr == `PCC_OFF_FEEDBACK);
    wire        wr_ms  = wr_en & (paddr == `PCC_OFF_MISC);
    wire        mapped = (paddr == `PCC_OFF_MISC) | (paddr == `PCC_OFF_FEEDBACK) |
                         (paddr == `PCC_OFF_STATUS) | (paddr == `PCC_OFF_IRQ_STAT) |
                         (paddr == `PCC_OFF_IRQ_MASK);

    wire [3:0]  lsel   = misc_ff[`PCC_MISC_LSEL_HI:`PCC_MISC_LSEL_LO];
    wire        gate   = misc_ff[`PCC_MISC_GATE_BIT];
    wire        awake;

    // Zero-wait slave; unmapped addresses answer with an error.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Register writes; reset values keep the part awake with outputs gated on.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc_ff     <= `PCC_MISC_RESET;
            fb_n_ff     <= `PCC_FB_N_RESET;
            pdiv_ff     <= `PCC_FB_PDIV_RESET;
            gain_ff     <= `PCC_FB_GAIN_RESET;
            irq_mask_ff <= 3'h0;
        end else begin
            if (wr_ms) begin
                misc_ff <= pwdata[7:0];
            end
            if (wr_fb) begin
                fb_n_ff <= pwdata[`PCC_FB_N_HI:`PCC_FB_N_LO];
                pdiv_ff <= pwdata[`PCC_FB_PDIV_HI:`PCC_FB_PDIV_LO];
                gain_ff <= pwdata[`PCC_FB_GAIN_HI:`PCC_FB_GAIN_LO];
            end
            if (wr_en & (paddr == `PCC_OFF_IRQ_MASK)) begin
                irq_mask_ff <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Calibration
    // ------------------------------------------------------------------
    // A new write restarts the count, so the last written setting wins.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_ff <= 16'h0000;
        end else if (clk_en) begin
            if (wr_fb) begin
                cal_cnt_ff <= `PCC_CAL_CYCLES;
            end else if (cal_cnt_ff != 16'h0000) begin
                cal_cnt_ff <= cal_cnt_ff - 16'h0001;
            end
        end
    end
    assign cal_busy = (cal_cnt_ff != 16'h0000) & awake;

    // ------------------------------------------------------------------
    // Power and output gating
    // ------------------------------------------------------------------
    assign device_sleep         = misc_ff[`PCC_MISC_SLEEP_BIT];
    assign awake                = ~device_sleep;
    assign lock_compare_quarter = misc_ff[`PCC_MISC_QUARTER_BIT] & awake;
    assign vco_tap_enable       = misc_ff[`PCC_MISC_TAP_BIT] & awake;
    // The external gate pin must also be high for any output to run.
    assign clock_out_enable = (gate & output_gate_pin & awake) ? per_output_gate : 8'h00;

    // ------------------------------------------------------------------
    // Feedback path
    // ------------------------------------------------------------------
    // Illegal post-divide codes stop the divider rather than bypass it.
    wire pdiv_ok = (pdiv_ff >= 4'h2) & (pdiv_ff <= 4'h8);
    wire fb_run  = awake & pdiv_ok & (fb_n_ff != 18'h00000);

    pcc_divider u_post_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .clk_en      (clk_en),
        .run         (awake & pdiv_ok),
        .divide      ({14'h0000, pdiv_ff}),
        .tick_in     (vco_tick),
        .tick_out_ff (dist_tick)
    );

    // Feedback counter counts post-divided ticks, so totals multiply.
    pcc_divider u_fb_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .clk_en      (clk_en),
        .run         (fb_run),
        .divide      (fb_n_ff),
        .tick_in     (dist_tick),
        .tick_out_ff (feedback_tick)
    );

    wire n_half;
    wire r_half;

    pcc_halver u_n_half (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .run     (fb_run),
        .tick_in (feedback_tick),
        .wave_ff (n_half)
    );

    pcc_halver u_r_half (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .run     (awake),
        .tick_in (ref_div_tick),
        .wave_ff (r_half)
    );

    // ------------------------------------------------------------------
    // Pump gain decode
    // ------------------------------------------------------------------
    // One-hot-ish gain multiplier as a plain number.
    always @* begin
        case (gain_ff)
            2'h0:    pump_gain = 6'h01;
            2'h1:    pump_gain = 6'h04;
            2'h2:    pump_gain = 6'h10;
            2'h3:    pump_gain = 6'h20;
            default: pump_gain = 6'h01;
        endcase
    end

    // ------------------------------------------------------------------
    // Lock status pin
    // ------------------------------------------------------------------
    // Open-drain codes only drive the active level and float otherwise.
    always @* begin
        lock_status_pin_o  = 1'b0;
        lock_status_pin_oe = 1'b0;
        if (awake) begin
            case (lsel)
                `PCC_LSEL_HIZ: begin
                    lock_status_pin_oe = 1'b0;
                end
                `PCC_LSEL_HIGH: begin
                    lock_status_pin_o  = 1'b1;
                    lock_status_pin_oe = 1'b1;
                end
                `PCC_LSEL_LOW: begin
                    lock_status_pin_o  = 1'b0;
                    lock_status_pin_oe = 1'b1;
                end
                `PCC_LSEL_DLD_H: begin
                    lock_status_pin_o  = digital_lock;
                    lock_status_pin_oe = 1'b1;
                end
                `PCC_LSEL_DLD_L: begin
                    lock_status_pin_o  = ~digital_lock;
                    lock_status_pin_oe = 1'b1;
                end
                `PCC_LSEL_ALD_PP: begin
                    lock_status_pin_o  = analog_lock;
                    lock_status_pin_oe = 1'b1;
                end
                `PCC_LSEL_ALD_NMOS: begin
                    lock_status_pin_o  = 1'b0;
                    lock_status_pin_oe = ~analog_lock;
                end
                `PCC_LSEL_ALD_PMOS: begin
                    lock_status_pin_o  = 1'b1;
                    lock_status_pin_oe = analog_lock;
                end
                `PCC_LSEL_NDIV2: begin
                    lock_status_pin_o  = n_half;
                    lock_status_pin_oe = 1'b1;
                end
                `PCC_LSEL_RDIV2: begin
                    lock_status_pin_o  = r_half;
                    lock_status_pin_oe = 1'b1;
                end
                default: begin
                    lock_status_pin_oe = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Events: calibration done, digital lock lost, digital lock gained.
    wire cal_done  = (cal_cnt_ff == 16'h0001) & clk_en & ~wr_fb;
    wire lock_lost = lock_prev_ff & ~digital_lock & clk_en;
    wire lock_got  = ~lock_prev_ff & digital_lock & clk_en;
    wire [2:0] evt = {lock_got, lock_lost, cal_done};
    wire [2:0] clr = (wr_en & (paddr == `PCC_OFF_IRQ_STAT)) ? pwdata[2:0] : 3'h0;

    // Set beats clear so a same-cycle event is not lost.
    always @* begin
        nxt_irq_stat = (irq_stat_ff & ~clr) | evt;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff  <= 3'h0;
            lock_prev_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (clk_en) begin
                lock_prev_ff <= digital_lock;
            end
        end
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Control registers are write-only and read as zero.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en & psel & ~penable & ~pwrite) begin
            case (paddr)
                `PCC_OFF_STATUS:   prdata <= {28'h0000000, analog_lock, digital_lock, device_sleep, cal_busy};
                `PCC_OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat_ff};
                `PCC_OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_ff};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// >>> pll_config_control_tb.sv
// Purpose: Self-checking bench for the PLL configuration block.
// Assumes: clk_en high except for one frozen write; tick sources run every cycle.
// Notes:   Reads are noted in a queue and judged by a bus monitor.
`timescale 1ns/10ps
module pll_config_control_tb;
    reg         pclk, presetn, clk_en, vco_tick, ref_div_tick, digital_lock, analog_lock, output_gate_pin, lo;
    reg  [7:0]  per_output_gate;
    wire        psel, penable, pwrite, pready, pslverr, lock_status_pin_o, lock_status_pin_oe, irq;
    wire        dist_tick, vco_tap_enable, feedback_tick, device_sleep, lock_compare_quarter, cal_busy;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [7:0]  clock_out_enable;
    wire [5:0]  pump_gain;
    // External pull-up on the lock pin.
    wire        lock_status_pin_i = lock_status_pin_oe ? lock_status_pin_o : 1'b1;
    integer     checked, miscompares, seed, dcnt, dgap, fcnt, fgap, tg, i, j, k, m;
    reg  [32:0] exp_q[$];
    reg  [1:0]  pe;

    pcc_top i_pcc_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .vco_tick, .ref_div_tick, .digital_lock, .analog_lock, .output_gate_pin,
        .per_output_gate, .lock_status_pin_i, .lock_status_pin_o, .lock_status_pin_oe, .clock_out_enable,
        .dist_tick, .vco_tap_enable, .feedback_tick, .device_sleep, .pump_gain, .lock_compare_quarter,
        .cal_busy, .irq);
    pcc_host i_pcc_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);

    always #25 pclk = ~pclk;

    // Pulse gaps and pin toggles, measured at every edge.
    always @(posedge pclk) begin
        dcnt <= dist_tick ? 1 : dcnt + 1;
        fcnt <= feedback_tick ? 1 : fcnt + 1;
        if (dist_tick) dgap <= dcnt;
        if (feedback_tick) fgap <= fcnt;
        tg <= tg + (lock_status_pin_o !== lo);
        lo <= lock_status_pin_o;
    end

    // Bus monitor: each completed read is judged against the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) check({pslverr, prdata}, exp_q.pop_front());
    end

    task check(input [63:0] seen, input [63:0] want);
        begin
            checked = checked + 1;
            if (seen !== want) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: saw %h want %h", $time, seen, want);
            end
        end
    endtask

    task complete_run;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        i_pcc_host.xfer(1'b1, a, d);
    endtask

    task rd(input [11:0] a, input [32:0] v);
        begin
            exp_q.push_back(v);
            i_pcc_host.xfer(1'b0, a, $random(seed));
        end
    endtask

    // Expected {drive enable, level} of the lock pin for one select code.
    function [1:0] pin_exp(input [3:0] c, input dl, input al);
        case (c)
            4'h1: pin_exp = 2'b11;
            4'h2: pin_exp = 2'b10;
            4'h3: pin_exp = {1'b1, dl};
            4'h4: pin_exp = {1'b1, !dl};
            4'h5: pin_exp = {1'b1, al};
            4'h6: pin_exp = {!al, 1'b0};
            4'h7: pin_exp = {al, 1'b1};
            4'h9, 4'hb: pin_exp = 2'b10;
            default: pin_exp = 2'b00;
        endcase
    endfunction

    // Watchdog, well beyond the few hundred microseconds the run needs.
    initial begin
        #1000000;
        miscompares = miscompares + 1;
        complete_run;
    end

    initial begin
        pclk = 0; presetn = 0; clk_en = 1; vco_tick = 1; ref_div_tick = 1; lo = 0;
        digital_lock = 0; analog_lock = 0; per_output_gate = 8'h5a;
        output_gate_pin = 1;
        checked = 0; miscompares = 0; seed = 77665; dcnt = 0; fcnt = 0; dgap = 0; fgap = 0; tg = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state: divide chain 2 x 760, pin floating, gate open, tap off.
        repeat (4560) @(posedge pclk);
        @(negedge pclk);
        check(dgap, 2);
        check(fgap, 1520);
        check({pump_gain, lock_status_pin_oe, vco_tap_enable, device_sleep}, {6'h01, 3'b000});
        check(clock_out_enable, 8'h5a);
        rd(12'h000, 33'h0);
        rd(12'h020, 33'h1_0000_0000);
        // Every post-divide code with N one below it; each write restarts calibration.
        for (i = 2; i <= 8; i = i + 1) begin
            k = i - 1;
            wr(12'h004, {8'h00, i[1:0], i[3:0], k[17:0]});
            rd(12'h008, 33'h1);
            repeat (4 * i * i) @(posedge pclk);
            @(negedge pclk);
            check(dgap, i);
            check(fgap, i * k);
            check(pump_gain, (i % 4 == 3) ? 32 : 1 << (2 * (i % 4)));
        end
        // An invalid post-divide code, then N of zero, stop the chain.
        for (j = 0; j < 2; j = j + 1) begin
            wr(12'h004, j ? 32'h0008_0000 : 32'h0024_0003);
            repeat (40) @(posedge pclk);
            @(negedge pclk);
            check((j ? fcnt : dcnt) > 30, 1);
        end
        // Every lock select code, twice, with random lock levels.
        wr(12'h004, 32'h0008_0001);
        for (i = 0; i < 16; i = i + 1) begin
            for (j = 0; j < 2; j = j + 1) begin
                wr(12'h000, 32'h20 | i);
                digital_lock <= $random(seed);
                analog_lock <= $random(seed);
                k = tg;
                repeat (40) @(posedge pclk);
                @(negedge pclk);
                pe = pin_exp(i, digital_lock, analog_lock);
                m = (i == 9) ? 20 : 40;
                check({lock_status_pin_oe, lock_status_pin_o & pe[1] & pe[0]}, {pe[1], pe[1] & pe[0]});
                if (i == 9 || i == 11) check(tg - k >= m - 2 && tg - k <= m + 2, 1);
            end
        end
        digital_lock <= 1'b0;
        analog_lock <= 1'b0;
        // Sleep, gate, tap and quarter bits in every combination.
        for (i = 0; i < 16; i = i + 1) begin
            output_gate_pin <= $random(seed);
            per_output_gate <= $random(seed);
            wr(12'h000, {24'h0, i[3:0], 4'h1});
            wr(12'h004, 32'h0008_0001);
            repeat (20) @(posedge pclk);
            @(negedge pclk);
            check(clock_out_enable, (i[1] && output_gate_pin && !i[0]) ? per_output_gate : 8'h00);
            check({device_sleep, lock_status_pin_oe, lock_compare_quarter}, {i[0], !i[0], i[3] & !i[0]});
            if (!i[0]) check(vco_tap_enable, i[2]);
            else check({dcnt > 15, cal_busy}, 2'b10);
        end
        // Calibration done: unmasked it raises irq, masked it only sets status.
        wr(12'h000, 32'h20);
        // A write while the clock enable is low must be dropped.
        clk_en <= 1'b0;
        wr(12'h000, 32'h30);
        clk_en <= 1'b1;
        @(negedge pclk);
        check(device_sleep, 0);
        for (j = 1; j >= 0; j = j - 1) begin
            wr(12'h010, j);
            wr(12'h00c, 32'h7);
            wr(12'h004, 32'h0008_0001);
            @(negedge pclk);
            k = 0;
            while (cal_busy === 1'b1 && k < 400) begin
                @(negedge pclk);
                k = k + 1;
            end
            check(k >= 199 && k <= 201, 1);
            check(irq, j);
            rd(12'h00c, 33'h1);
            rd(12'h010, j);
            wr(12'h00c, 32'h1);
            @(negedge pclk);
            check(irq, 0);
        end
        complete_run;
    end
endmodule
